/* sadc_consts.vh */
// Purpose: Constants for the converter mode and conversion control block
// Assumes: 125 MHz system clock
// Notes: Counts derived from times in their own units
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
`define SADC_CLK_MHZ 125
`define SADC_SETTLE_US 80
`define SADC_SETTLE_CYC (`SADC_SETTLE_US * `SADC_CLK_MHZ)
`define SADC_CONV_DIV 4
`define SADC_BITS 16
`define SADC_CHANS 6
`define SADC_NPIN 9
`define SADC_P_REFERENCE_SOURCE_SELECT 0
`define SADC_P_SPAN 1
`define SADC_P_PDN 2
`define SADC_P_IFSEL 3
`define SADC_P_MSBSEL 4
`define SADC_P_STA 5
`define SADC_P_STB 6
`define SADC_P_CSN 7
`define SADC_P_RDCLK 8
`define SADC_SYNC_RST 9'h184
`define SADC_ST_IDLE 3'h1
`define SADC_ST_CONV 3'h2
`define SADC_ST_PUSH 3'h4
`endif

/* sadc_ctrl.v */
// Purpose: Mode, power, conversion start and readout control of a six-channel SAR converter
// Assumes: Pins asynchronous to sys_clk_in; sample_data_in stable while hold is asserted
// Notes: Results pass a two-entry buffer into the output registers
`timescale 1ns/1ps
`include "sadc_consts.vh"

module sadc_ctrl #(
  parameter SETTLE_CYC = `SADC_SETTLE_CYC,
  parameter CONV_DIV = `SADC_CONV_DIV,
  parameter BITS = `SADC_BITS,
  parameter CHANS = `SADC_CHANS
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire reference_source_select_in,
  input wire input_span_select_in,
  input wire power_down_n_in,
  input wire interface_select_in,
  input wire msb_or_byte_select_in,
  input wire sample_start_group_a_in,
  input wire sample_start_group_b_in,
  input wire host_select_n_in,
  input wire read_strobe_or_serial_clock_in,
  input wire [CHANS*BITS-1:0] sample_data_in,
  output reg int_ref_enable_out,
  output reg ref_pin_drive_out,
  output reg ref_buffer_enable_out,
  output reg span_10v_out,
  output reg span_settling_out,
  output reg standby_out,
  output reg shutdown_out,
  output reg hold_a_out,
  output reg hold_b_out,
  output reg busy_out,
  output reg [BITS-1:0] data_bus_out,
  output reg data_bus_oe_out,
  output reg msb_or_byte_select_out,
  output reg msb_or_byte_select_oe_out,
  output reg serial_out_a_out,
  output reg serial_out_a_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release (three stages, edge flops settle first) and pin synchronisers
  reg [2:0] rst_sync_q;
  wire rst_loc;
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_sync_q <= 3'h7;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], 1'b0};
    end
  end
  assign rst_loc = rst_in | rst_sync_q[2];

  wire [`SADC_NPIN-1:0] pin_raw;
  wire [`SADC_NPIN-1:0] pin_s;
  wire [`SADC_NPIN-1:0] sync_rst = `SADC_SYNC_RST;
  assign pin_raw = {read_strobe_or_serial_clock_in, host_select_n_in,
                    sample_start_group_b_in, sample_start_group_a_in,
                    msb_or_byte_select_in, interface_select_in, power_down_n_in,
                    input_span_select_in, reference_source_select_in};
  genvar gi;
  generate
    for (gi = 0; gi < `SADC_NPIN; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          s1_q <= sync_rst[gi];
          s2_q <= sync_rst[gi];
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_s[gi] = s2_q;
    end
  endgenerate

  reg [`SADC_NPIN-1:0] prev_q;
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= `SADC_SYNC_RST;
    end else begin
      prev_q <= pin_s;
    end
  end

  wire reference_source_select = pin_s[`SADC_P_REFERENCE_SOURCE_SELECT];
  wire span = pin_s[`SADC_P_SPAN];
  wire pd_n = pin_s[`SADC_P_PDN];
  wire cs_n = pin_s[`SADC_P_CSN];
  wire rdclk = pin_s[`SADC_P_RDCLK];
  wire mode_par = ~pin_s[`SADC_P_IFSEL];
  wire mode_ser = pin_s[`SADC_P_IFSEL] & ~pin_s[`SADC_P_MSBSEL];
  wire mode_byte = pin_s[`SADC_P_IFSEL] & pin_s[`SADC_P_MSBSEL];
  wire rise_a = pin_s[`SADC_P_STA] & ~prev_q[`SADC_P_STA];
  wire rise_b = pin_s[`SADC_P_STB] & ~prev_q[`SADC_P_STB];
  wire cs_fall = prev_q[`SADC_P_CSN] & ~cs_n;
  wire cs_rise = ~prev_q[`SADC_P_CSN] & cs_n;
  wire rd_fall = prev_q[`SADC_P_RDCLK] & ~rdclk & ~cs_n;
  wire sclk_rise = ~prev_q[`SADC_P_RDCLK] & rdclk & ~cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Reference, span and power modes
  reg [13:0] settle_q;
  wire shut_d = ~pd_n & span;
  always @(posedge sys_clk_in or posedge rst_loc) begin
    if (rst_loc) begin
      int_ref_enable_out <= 1'b0;
      ref_pin_drive_out <= 1'b0;
      ref_buffer_enable_out <= 1'b0;
      span_10v_out <= 1'b0;
      span_settling_out <= 1'b0;
      standby_out <= 1'b0;
      shutdown_out <= 1'b0;
      settle_q <= 14'h0000;
    end else begin
      int_ref_enable_out <= reference_source_select & ~shut_d;
      ref_pin_drive_out <= reference_source_select & ~shut_d;
      ref_buffer_enable_out <= ~shut_d;
      span_10v_out <= span;
      standby_out <= ~pd_n & ~span;
      shutdown_out <= shut_d;
      if (pin_s[`SADC_P_SPAN] != prev_q[`SADC_P_SPAN] && pd_n) begin
        settle_q <= SETTLE_CYC[13:0];
        span_settling_out <= 1'b1;
      end else if (settle_q != 14'h0000) begin
        settle_q <= settle_q - 14'h0001;
        span_settling_out <= (settle_q != 14'h0001);
      end else begin
        span_settling_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start capture and internal-clock conversion
  reg [2:0] st_q;
  reg seen_a_q;
  reg seen_b_q;
  reg [CHANS*BITS-1:0] held_q;
  reg [3:0] div_q;
  reg [4:0] bit_q;
  reg [2:0] cch_q;
  reg [2:0] wr_idx_q;
  wire tick = (div_q == CONV_DIV[3:0] - 4'h1);
  wire push_ready;
  wire push_valid = (st_q == `SADC_ST_PUSH);
  wire [BITS-1:0] push_word = held_q[cch_q*BITS +: BITS];
  wire pop_valid;
  wire pop_ready = cs_n; // Output registers frozen during a frame
  wire [BITS-1:0] pop_word;
  wire all_latched = pop_valid & pop_ready & (wr_idx_q == CHANS[2:0] - 3'h1);

  always @(posedge sys_clk_in or posedge rst_loc) begin
    if (rst_loc) begin
      st_q <= `SADC_ST_IDLE;
      seen_a_q <= 1'b0;
      seen_b_q <= 1'b0;
      hold_a_out <= 1'b0;
      hold_b_out <= 1'b0;
      busy_out <= 1'b0;
      held_q <= {CHANS*BITS{1'b0}};
      div_q <= 4'h0;
      bit_q <= 5'h00;
      cch_q <= 3'h0;
    end else begin
      case (st_q)
        `SADC_ST_IDLE: begin
          if (pd_n & ~busy_out) begin
            if (rise_a) begin
              seen_a_q <= 1'b1;
              hold_a_out <= 1'b1;
              held_q[3*BITS-1:0] <= sample_data_in[3*BITS-1:0];
            end
            if (rise_b) begin
              seen_b_q <= 1'b1;
              hold_b_out <= 1'b1;
              held_q[CHANS*BITS-1:3*BITS] <= sample_data_in[CHANS*BITS-1:3*BITS];
            end
            if ((seen_a_q | rise_a) & (seen_b_q | rise_b)) begin
              busy_out <= 1'b1;
              st_q <= `SADC_ST_CONV;
              div_q <= 4'h0;
              bit_q <= 5'h00;
              cch_q <= 3'h0;
            end
          end
        end
        `SADC_ST_CONV: begin
          div_q <= tick ? 4'h0 : div_q + 4'h1;
          if (tick) begin
            if (bit_q == BITS[4:0] - 5'h01) begin
              bit_q <= 5'h00;
              st_q <= `SADC_ST_PUSH;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end
        end
        `SADC_ST_PUSH: begin
          if (push_ready) begin
            if (cch_q == CHANS[2:0] - 3'h1) begin
              st_q <= `SADC_ST_IDLE;
              hold_a_out <= 1'b0;
              hold_b_out <= 1'b0;
              seen_a_q <= 1'b0;
              seen_b_q <= 1'b0;
            end else begin
              cch_q <= cch_q + 3'h1;
              st_q <= `SADC_ST_CONV;
            end
          end
        end
        default: begin
          st_q <= `SADC_ST_IDLE;
        end
      endcase
      if (all_latched) begin
        busy_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry result buffer
  reg [BITS-1:0] fifo_q [0:1];
  reg fw_q;
  reg fr_q;
  reg [1:0] fcnt_q;
  wire do_push = push_valid & push_ready;
  wire do_pop = pop_valid & pop_ready;
  assign push_ready = (fcnt_q != 2'h2);
  assign pop_valid = (fcnt_q != 2'h0);
  assign pop_word = fifo_q[fr_q];
  always @(posedge sys_clk_in or posedge rst_loc) begin
    if (rst_loc) begin
      fifo_q[0] <= {BITS{1'b0}};
      fifo_q[1] <= {BITS{1'b0}};
      fw_q <= 1'b0;
      fr_q <= 1'b0;
      fcnt_q <= 2'h0;
    end else begin
      if (do_push) begin
        fifo_q[fw_q] <= push_word;
        fw_q <= ~fw_q;
      end
      if (do_pop) begin
        fr_q <= ~fr_q;
      end
      if (do_push & ~do_pop) begin
        fcnt_q <= fcnt_q + 2'h1;
      end else if (~do_push & do_pop) begin
        fcnt_q <= fcnt_q - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data registers and readout
  reg [BITS-1:0] res_q [0:CHANS-1];
  reg [2:0] rptr_q;
  reg byte_lo_q;
  reg [BITS-1:0] sh_q;
  reg [3:0] sbit_q;
  integer i;
  wire [2:0] rptr_nx = (rptr_q == CHANS[2:0] - 3'h1) ? 3'h0 : rptr_q + 3'h1;
  wire [BITS-1:0] cur_word = res_q[rptr_q];
  wire [BITS-1:0] nx_word = res_q[rptr_nx];

  always @(posedge sys_clk_in or posedge rst_loc) begin
    if (rst_loc) begin
      for (i = 0; i < CHANS; i = i + 1) begin
        res_q[i] <= {BITS{1'b0}};
      end
      wr_idx_q <= 3'h0;
      rptr_q <= 3'h0;
      byte_lo_q <= 1'b0;
      sh_q <= {BITS{1'b0}};
      sbit_q <= 4'h0;
      data_bus_out <= {BITS{1'b0}};
      data_bus_oe_out <= 1'b0;
      msb_or_byte_select_out <= 1'b0;
      msb_or_byte_select_oe_out <= 1'b0;
      serial_out_a_out <= 1'b0;
      serial_out_a_oe_out <= 1'b0;
    end else begin
      if (do_pop) begin
        res_q[wr_idx_q] <= pop_word;
        wr_idx_q <= (wr_idx_q == CHANS[2:0] - 3'h1) ? 3'h0 : wr_idx_q + 3'h1;
      end
      data_bus_oe_out <= ~cs_n & ~rdclk & (mode_par | mode_byte);
      msb_or_byte_select_oe_out <= ~cs_n & ~rdclk & mode_par;
      if (cs_fall) begin
        rptr_q <= 3'h0;
        byte_lo_q <= 1'b0;
        sbit_q <= 4'h0;
        sh_q <= res_q[0];
        serial_out_a_out <= res_q[0][BITS-1];
        serial_out_a_oe_out <= mode_ser;
      end else if (cs_rise) begin
        serial_out_a_oe_out <= 1'b0;
      end else if (rd_fall & mode_par) begin
        data_bus_out <= cur_word;
        msb_or_byte_select_out <= cur_word[BITS-1];
        rptr_q <= rptr_nx;
      end else if (rd_fall & mode_byte) begin
        data_bus_out <= {8'h00, byte_lo_q ? cur_word[7:0] : cur_word[15:8]};
        byte_lo_q <= ~byte_lo_q;
        if (byte_lo_q) begin
          rptr_q <= rptr_nx;
        end
      end else if (sclk_rise & mode_ser) begin
        if (sbit_q == BITS[3:0] - 4'h1) begin
          sbit_q <= 4'h0;
          rptr_q <= rptr_nx;
          sh_q <= nx_word;
          serial_out_a_out <= nx_word[BITS-1];
        end else begin
          sbit_q <= sbit_q + 4'h1;
          sh_q <= {sh_q[BITS-2:0], 1'b0};
          serial_out_a_out <= sh_q[BITS-2];
        end
      end
    end
  end

endmodule // sadc_ctrl

/* sadc_ctrl_chk.sv */
// Purpose: Port assertions for sadc_ctrl
// Assumes: Bound from the testbench top
// Notes: Level checks wait for settled logic
`timescale 1ns/1ps
module sadc_ctrl_chk #(
  parameter BITS = 16
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire reference_source_select_in,
  input wire input_span_select_in,
  input wire power_down_n_in,
  input wire sample_start_group_a_in,
  input wire host_select_n_in,
  input wire read_strobe_or_serial_clock_in,
  input wire int_ref_enable_out,
  input wire ref_pin_drive_out,
  input wire ref_buffer_enable_out,
  input wire span_10v_out,
  input wire standby_out,
  input wire shutdown_out,
  input wire hold_a_out,
  input wire hold_b_out,
  input wire busy_out,
  input wire [BITS-1:0] data_bus_out,
  input wire data_bus_oe_out,
  input wire msb_or_byte_select_oe_out,
  input wire serial_out_a_oe_out
);
  ////////////////////////////////////////
  reg [2:0] up_q;
  wire [2:0] up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  wire g = (up_q == 3'h7);
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) up_q <= 3'h0;
    else up_q <= up_d;
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  a_int_ref_on: assert property ((g && reference_source_select_in && power_down_n_in)[*6]
    |-> int_ref_enable_out && ref_pin_drive_out && ref_buffer_enable_out)
    else $error("internal reference off");
  a_ext_ref_off: assert property ((g && !reference_source_select_in)[*6]
    |-> !int_ref_enable_out && !ref_pin_drive_out) else $error("band-gap still on");
  a_span_level: assert property ((g && $stable(input_span_select_in))[*6]
    |-> span_10v_out == input_span_select_in) else $error("span wrong");
  a_pd_kind: assert property ((g && !power_down_n_in && $stable(input_span_select_in))[*6]
    |-> standby_out != input_span_select_in && shutdown_out == input_span_select_in
    && ref_buffer_enable_out != input_span_select_in) else $error("power-down kind wrong");
  a_bus_idle: assert property ((g && (host_select_n_in || read_strobe_or_serial_clock_in))[*6]
    |-> !data_bus_oe_out && !msb_or_byte_select_oe_out) else $error("bus driven");
  a_cs_release: assert property ((g && host_select_n_in)[*6]
    |-> !serial_out_a_oe_out && !data_bus_oe_out) else $error("outputs not released");
  a_busy_both: assert property (hold_a_out != hold_b_out |-> !busy_out)
    else $error("busy with one group");
  a_busy_hold: assert property ($rose(busy_out) |-> hold_a_out && hold_b_out)
    else $error("busy without hold");
  a_busy_ends: assert property ($rose(busy_out) |-> ##[1:1000] !busy_out)
    else $error("busy stuck");
  a_start_hold: assert property ((g && power_down_n_in)[*6] ##0
    (!busy_out && !hold_a_out && $rose(sample_start_group_a_in)) |-> ##[2:6] hold_a_out)
    else $error("group a not held");
  a_reset_clear: assert property (disable iff (1'b0) rst_in |-> !busy_out && !hold_a_out
    && !(|data_bus_out) && !data_bus_oe_out && !serial_out_a_oe_out) else $error("reset state");
endmodule // sadc_ctrl_chk

/* sadc_host.sv */
// Purpose: Host model driving select and read strobe or serial clock
// Assumes: Tasks entered at a falling system clock edge
// Notes: Serial clock idles high, runs only inside frames
`timescale 1ns/1ps
module sadc_host (
  input wire sys_clk_in,
  input wire [16:0] data_in,
  input wire serial_in,
  output reg host_select_n_out,
  output reg read_strobe_or_serial_clock_out
);
  initial begin
    host_select_n_out = 1'b1;
    read_strobe_or_serial_clock_out = 1'b1;
  end
  ////////////////////////////////////////
  task sel(input b);
    @(negedge sys_clk_in);
    host_select_n_out = b;
    repeat (6) @(negedge sys_clk_in);
  endtask
  task strobe(output [16:0] d);
    read_strobe_or_serial_clock_out = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    d = data_in;
    read_strobe_or_serial_clock_out = 1'b1;
    repeat (6) @(negedge sys_clk_in);
  endtask
  task shift(output [16:0] d);
    integer i;
    d = 17'h00000;
    for (i = 15; i >= 0; i = i - 1) begin
      d[i] = serial_in;
      read_strobe_or_serial_clock_out = 1'b0;
      repeat (5) @(negedge sys_clk_in);
      read_strobe_or_serial_clock_out = 1'b1;
      repeat (5) @(negedge sys_clk_in);
    end
    @(negedge sys_clk_in);
  endtask
endmodule // sadc_host

/* sadc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for sadc_ctrl
// Assumes: Host model owns select and strobe
// Notes: Short settle and conversion counts
`timescale 1ns/1ps
module sadc_ctrl_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b0;
  reg reference_source_select = 1'b0;
  reg span = 1'b0;
  reg pdn = 1'b1;
  reg ifsel = 1'b0;
  reg msb_drv = 1'b0;
  reg sta = 1'b0;
  reg stb = 1'b0;
  reg flip = 1'b0;
  wire cs_n, rd, int_ref, buf_en, span10, settling, standby, shutdown;
  wire hold_a, hold_b, ref_pin, busy, bus_oe, msb_out, msb_oe, ser, ser_oe;
  wire [15:0] bus;
  wire [95:0] samp;
  reg [16:0] d;
  reg [15:0] e;
  integer i;
  integer miscompares = 0;
  integer check_count = 0;
  function [15:0] ev(input integer k);
    ev = 16'h9C31 + k[15:0] * 16'h2B15;
  endfunction
  genvar j;
  for (j = 0; j < 6; j = j + 1) begin : g_samp
    assign samp[16*j+:16] = ev(j) ^ {16{flip}};
  end
  always #4 clk = ~clk;
  ////////////////////////////////////////
  sadc_ctrl #(.SETTLE_CYC(20), .CONV_DIV(1)) i_sadc_ctrl (
    .sys_clk_in(clk), .rst_in(rst), .reference_source_select_in(reference_source_select),
    .input_span_select_in(span), .power_down_n_in(pdn), .interface_select_in(ifsel),
    .msb_or_byte_select_in(msb_oe ? msb_out : msb_drv), .sample_start_group_a_in(sta),
    .sample_start_group_b_in(stb), .host_select_n_in(cs_n),
    .read_strobe_or_serial_clock_in(rd), .sample_data_in(samp),
    .int_ref_enable_out(int_ref), .ref_pin_drive_out(ref_pin), .ref_buffer_enable_out(buf_en),
    .span_10v_out(span10), .span_settling_out(settling), .standby_out(standby),
    .shutdown_out(shutdown), .hold_a_out(hold_a), .hold_b_out(hold_b), .busy_out(busy),
    .data_bus_out(bus), .data_bus_oe_out(bus_oe), .msb_or_byte_select_out(msb_out),
    .msb_or_byte_select_oe_out(msb_oe), .serial_out_a_out(ser), .serial_out_a_oe_out(ser_oe));
  sadc_host i_sadc_host (.sys_clk_in(clk), .data_in({msb_out, bus}), .serial_in(ser),
    .host_select_n_out(cs_n), .read_strobe_or_serial_clock_out(rd));
  ////////////////////////////////////////
  task give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [16:0] got, input [16:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task st;
    repeat (8) @(negedge clk);
  endtask
  task do_rst;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    st;
  endtask
  task wbusy(input v);
    integer n;
    n = 0;
    while (busy !== v && n < 2000) begin
      @(negedge clk);
      n = n + 1;
    end
    if (busy !== v) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  endtask
  task conv(input both);
    sta = 1'b0;
    stb = 1'b0;
    st;
    sta = 1'b1;
    stb = both;
    st;
    chk(busy, both);
    chk(hold_a, 1'b1);
    chk(hold_b, both);
    stb = 1'b1;
    wbusy(1'b1);
    flip = ~flip;
  endtask
  ////////////////////////////////////////
  initial begin
    #1 rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    st;
    for (i = 0; i < 4; i = i + 1) begin
      reference_source_select = i[0];
      span = i[1];
      st;
      chk(int_ref, i[0]);
      chk(ref_pin, i[0]);
      chk(span10, i[1]);
      chk(settling, i[1]);
      chk(buf_en, 1'b1);
    end
    repeat (20) @(negedge clk);
    chk(settling, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      span = i[0];
      pdn = 1'b0;
      sta = 1'b1;
      stb = 1'b1;
      st;
      chk(standby, !i[0]);
      chk(shutdown, i[0]);
      chk(int_ref, !i[0]);
      chk(busy, 1'b0);
      sta = 1'b0;
      stb = 1'b0;
      pdn = 1'b1;
      st;
    end
    do_rst;
    conv(1'b0);
    wbusy(1'b0);
    i_sadc_host.sel(1'b0);
    for (i = 0; i < 6; i = i + 1) begin
      i_sadc_host.strobe(d);
      e = ev(i);
      chk(d, {e[15], e});
    end
    i_sadc_host.sel(1'b1);
    chk(bus_oe, 1'b0);
    ifsel = 1'b1;
    msb_drv = 1'b1;
    i_sadc_host.sel(1'b0);
    for (i = 0; i < 12; i = i + 1) begin
      i_sadc_host.strobe(d);
      e = ev(i >> 1);
      chk(d & 17'h0FFFF, i[0] ? {9'h000, e[7:0]} : {9'h000, e[15:8]});
    end
    i_sadc_host.sel(1'b1);
    msb_drv = 1'b0;
    i_sadc_host.sel(1'b0);
    chk(ser_oe, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
      i_sadc_host.shift(d);
      chk(d, {1'b0, ev(i)});
    end
    i_sadc_host.sel(1'b1);
    chk(ser_oe, 1'b0);
    conv(1'b1);
    do_rst;
    chk(busy, 1'b0);
    chk(hold_b, 1'b0);
    ifsel = 1'b0;
    i_sadc_host.sel(1'b0);
    i_sadc_host.strobe(d);
    chk(d, 17'h00000);
    i_sadc_host.sel(1'b1);
    give_verdict;
  end
endmodule // sadc_ctrl_tb_top

bind sadc_ctrl sadc_ctrl_chk #(.BITS(BITS)) i_sadc_ctrl_chk (
  .sys_clk_in, .rst_in, .reference_source_select_in, .input_span_select_in,
  .power_down_n_in, .sample_start_group_a_in, .host_select_n_in,
  .read_strobe_or_serial_clock_in, .int_ref_enable_out, .ref_pin_drive_out,
  .ref_buffer_enable_out, .span_10v_out, .standby_out, .shutdown_out, .hold_a_out,
  .hold_b_out, .busy_out, .data_bus_out, .data_bus_oe_out,
  .msb_or_byte_select_oe_out, .serial_out_a_oe_out);
